// ==== inc/sgc_cfg.svh ====
// Offsets, reset values and field positions of the global configuration bank.
// Assumes an 8-bit register port with 8-bit addresses.
`ifndef SGC_CFG_SVH
`define SGC_CFG_SVH

`define SGC_AW            8
`define SGC_DW            8
`define SGC_ADDR_CTL      8'h0B
`define SGC_ADDR_MAP_LO   8'h0C
`define SGC_ADDR_MAP_HI   8'h0D
`define SGC_ADDR_UNK      8'h0E
`define SGC_ADDR_PHY      8'h0F

`define SGC_RST_CTL       8'h08
`define SGC_RST_MAP_LO    8'h50
`define SGC_RST_MAP_HI    8'hFA
`define SGC_RST_UNK       8'h07
`define SGC_RST_PHY       5'h01
`define SGC_PHY_BAD_HI0   5'h1E
`define SGC_PHY_BAD_HI1   5'h1F
`define SGC_PHY_BAD_LO    5'h00
`define SGC_PHY_STEP      5'h01
`define SGC_PHY_LSB       3
`define SGC_PHY_RSV       3'h0

`define SGC_BIT_LED_HI    7
`define SGC_BIT_FILTER    5
`define SGC_BIT_TEST      4
`define SGC_BIT_POS_HI    3
`define SGC_BIT_POS_LO    2
`define SGC_BIT_LED_LO    1
`define SGC_BIT_TPID      0
`define SGC_BIT_UNK_EN    7

`define SGC_STRAP_CAP     2'h2
`define SGC_STRAP_DONE    2'h3

`endif

// ==== inc/sgc_pkg.sv ====
// Types shared by the global configuration bank.
// Assumes sgc_cfg.svh is available on the include path.
`default_nettype none
package sgc_pkg;
  typedef enum logic [1:0] {
    SGC_POS_P2_COPPER = 2'h0,
    SGC_POS_P2_MAC    = 2'h1,
    SGC_POS_P1_OPTIC  = 2'h2
  } sgc_pos_t;

  typedef struct packed {
    logic [3:0] strap_s1;
    logic [3:0] strap_s2;
    logic [1:0] cap_cnt;
    logic [7:0] ctl;
    logic [7:0] map_lo;
    logic [7:0] map_hi;
    logic [7:0] unk;
    logic [4:0] phy;
    logic [7:0] rdata;
    sgc_pos_t   pos;
    logic       drop;
    logic       pass;
    logic [1:0] prio;
    logic       prio_vld;
    logic [2:0] fwd_mask;
    logic       fwd_vld;
    logic       hit1;
    logic       hit2;
    logic       phy_ok;
  } sgc_state_t;
endpackage
`default_nettype wire

// ==== logic/sgc_regs.sv ====
// Global configuration bank: loopback, LED, tag mode, priority map, unknown
// forwarding and PHY base address. Assumes straps are asynchronous pins and
// the management port and frame inputs are synchronous to CLK.
`include "sgc_cfg.svh"
`default_nettype none
module sgc_regs (
  input  wire logic       CLK,               // 40 MHz switch clock
  input  wire logic       RESET_N,           // Chip reset, async, active low
  input  wire logic       STRAP_FILTER,      // Loop filter strap pin
  input  wire logic       STRAP_POS,         // Loop position low strap pin
  input  wire logic       STRAP_LED_LO,      // LED select low strap pin
  input  wire logic       STRAP_LED_HI,      // LED select high strap pin
  input  wire logic       REG_WR,            // Register write strobe
  input  wire logic       REG_RD,            // Register read strobe
  input  wire logic [7:0] REG_ADDR,          // Register address
  input  wire logic [7:0] REG_WDATA,         // Write data
  output logic      [7:0] REG_RDATA,         // Read data, one cycle after strobe
  output logic            LOOP_FILTER,       // Loopback filter enable
  output logic            TEST_MODE,         // Test mode bit
  output logic      [1:0] LOOP_POS,          // Decoded loopback position
  output logic      [1:0] LED_MODE,          // {high, low} LED select
  output logic            DIRECT_TAG_EN,     // Direct forwarding tag mode
  input  wire logic       FRM_END,           // Loopback frame finished
  input  wire logic       FRM_OAM,           // Frame is maintenance frame
  input  wire logic       FRM_CRC_ERR,       // Bad CRC
  input  wire logic       FRM_RUNT,          // Undersize
  input  wire logic       FRM_GIANT,         // Oversize
  output logic            LOOP_DROP,         // Pulse: frame discarded
  output logic            LOOP_PASS,         // Pulse: frame looped back
  input  wire logic       TAG_VALID,         // Tagged frame priority request
  input  wire logic [2:0] TAG_PRIO,          // Tag priority value
  output logic      [1:0] PRIO_QUEUE,        // Mapped queue
  output logic            PRIO_VALID,        // Pulse: PRIO_QUEUE valid
  input  wire logic       DA_VALID,          // Destination lookup done
  input  wire logic       DA_UNKNOWN,        // Destination not learned
  input  wire logic [2:0] DA_PORTS,          // Ports chosen otherwise
  output logic      [2:0] FWD_PORTS,         // Ports to forward to
  output logic            FWD_VALID,         // Pulse: FWD_PORTS valid
  input  wire logic       MIIM_VALID,        // PHY management access
  input  wire logic [4:0] MIIM_PHY,          // Addressed PHY
  output logic            MIIM_HIT_P1,       // Pulse: access for port 1 PHY
  output logic            MIIM_HIT_P2,       // Pulse: access for port 2 PHY
  output logic      [4:0] PHY_ADDR,          // Port 1 PHY address
  output logic            PHY_ADDR_OK        // Address is a valid code
);
  sgc_pkg::sgc_state_t q, d;

  function automatic logic [1:0] map_lookup(input logic [15:0] map, input logic [2:0] tp);
    map_lookup = map[{tp, 1'b0} +: 2];
  endfunction

  function automatic logic phy_valid(input logic [4:0] a);
    phy_valid = (a != `SGC_PHY_BAD_LO) && (a != `SGC_PHY_BAD_HI0) && (a != `SGC_PHY_BAD_HI1);
  endfunction

  always_comb begin
    d = q;
    // Strap pins are asynchronous: two flops before use
    d.strap_s1 = {STRAP_LED_HI, STRAP_FILTER, STRAP_POS, STRAP_LED_LO};
    d.strap_s2 = q.strap_s1;
    if (q.cap_cnt != `SGC_STRAP_DONE) begin
      d.cap_cnt = q.cap_cnt + 2'h1;
    end
    if (REG_WR) begin
      case (REG_ADDR)
        `SGC_ADDR_CTL:    d.ctl = REG_WDATA;
        `SGC_ADDR_MAP_LO: d.map_lo = REG_WDATA;
        `SGC_ADDR_MAP_HI: d.map_hi = REG_WDATA;
        `SGC_ADDR_UNK:    d.unk = REG_WDATA;
        `SGC_ADDR_PHY:    d.phy = REG_WDATA[7:`SGC_PHY_LSB];
        default:          d.unk = q.unk;
      endcase
    end
    // Strap capture once synchronisers settle; overrides a write in the same cycle
    if (q.cap_cnt == `SGC_STRAP_CAP) begin
      d.ctl[`SGC_BIT_LED_HI] = q.strap_s2[3];
      d.ctl[`SGC_BIT_FILTER] = q.strap_s2[2];
      d.ctl[`SGC_BIT_POS_LO] = q.strap_s2[1];
      d.ctl[`SGC_BIT_LED_LO] = q.strap_s2[0];
    end
    d.rdata = 8'h00;
    if (REG_RD) begin
      case (REG_ADDR)
        `SGC_ADDR_CTL:    d.rdata = q.ctl;
        `SGC_ADDR_MAP_LO: d.rdata = q.map_lo;
        `SGC_ADDR_MAP_HI: d.rdata = q.map_hi;
        `SGC_ADDR_UNK:    d.rdata = q.unk;
        `SGC_ADDR_PHY:    d.rdata = {q.phy, `SGC_PHY_RSV};
        default:          d.rdata = 8'h00;
      endcase
    end
    // Low position bit wins regardless of the high bit
    if (q.ctl[`SGC_BIT_POS_LO]) begin
      d.pos = sgc_pkg::SGC_POS_P1_OPTIC;
    end else if (q.ctl[`SGC_BIT_POS_HI]) begin
      d.pos = sgc_pkg::SGC_POS_P2_MAC;
    end else begin
      d.pos = sgc_pkg::SGC_POS_P2_COPPER;
    end
    d.drop = FRM_END && (FRM_OAM || (q.ctl[`SGC_BIT_FILTER] &&
             (FRM_CRC_ERR || FRM_RUNT || FRM_GIANT)));
    d.pass = FRM_END && !d.drop;
    d.prio_vld = TAG_VALID;
    d.prio = TAG_VALID ? map_lookup({q.map_hi, q.map_lo}, TAG_PRIO) : q.prio;
    d.fwd_vld = DA_VALID;
    if (DA_VALID) begin
      d.fwd_mask = (DA_UNKNOWN && q.unk[`SGC_BIT_UNK_EN]) ? q.unk[2:0] : DA_PORTS;
    end
    d.phy_ok = phy_valid(q.phy);
    // Gate on the live code, not the lagging flag: a fresh invalid code never answers
    d.hit1 = MIIM_VALID && phy_valid(q.phy) && (MIIM_PHY == q.phy);
    d.hit2 = MIIM_VALID && phy_valid(q.phy) && (MIIM_PHY == q.phy + `SGC_PHY_STEP);
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      q          <= '0;
      q.ctl      <= `SGC_RST_CTL;
      q.map_lo   <= `SGC_RST_MAP_LO;
      q.map_hi   <= `SGC_RST_MAP_HI;
      q.unk      <= `SGC_RST_UNK;
      q.phy      <= `SGC_RST_PHY;
      q.pos      <= sgc_pkg::SGC_POS_P2_MAC;
      q.fwd_mask <= 3'h7;
      q.phy_ok   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign REG_RDATA     = q.rdata;
  assign LOOP_FILTER   = q.ctl[`SGC_BIT_FILTER];
  assign TEST_MODE     = q.ctl[`SGC_BIT_TEST];
  assign LOOP_POS      = q.pos;
  assign LED_MODE      = {q.ctl[`SGC_BIT_LED_HI], q.ctl[`SGC_BIT_LED_LO]};
  assign DIRECT_TAG_EN = q.ctl[`SGC_BIT_TPID];
  assign LOOP_DROP     = q.drop;
  assign LOOP_PASS     = q.pass;
  assign PRIO_QUEUE    = q.prio;
  assign PRIO_VALID    = q.prio_vld;
  assign FWD_PORTS     = q.fwd_mask;
  assign FWD_VALID     = q.fwd_vld;
  assign MIIM_HIT_P1   = q.hit1;
  assign MIIM_HIT_P2   = q.hit2;
  assign PHY_ADDR      = q.phy;
  assign PHY_ADDR_OK   = q.phy_ok;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  property p_filter_drop;
    FRM_END && !FRM_OAM && LOOP_FILTER && (FRM_CRC_ERR || FRM_RUNT) |=> LOOP_DROP && !LOOP_PASS;
  endproperty
  a_filter_drop: assert property (p_filter_drop) else $error("Errored frame not dropped");

  property p_nofilter_pass;
    FRM_END && !FRM_OAM && !LOOP_FILTER |=> LOOP_PASS && !LOOP_DROP;
  endproperty
  a_nofilter_pass: assert property (p_nofilter_pass) else $error("Frame not looped");

  property p_oam_drop;
    FRM_END && FRM_OAM |=> LOOP_DROP;
  endproperty
  a_oam_drop: assert property (p_oam_drop) else $error("Maintenance frame looped");

  property p_pos;
    q.ctl[`SGC_BIT_POS_LO] |=> LOOP_POS == sgc_pkg::SGC_POS_P1_OPTIC;
  endproperty
  a_pos: assert property (p_pos) else $error("Optic loop position wrong");

  property p_prio;
    TAG_VALID |=> PRIO_VALID && PRIO_QUEUE == map_lookup($past({q.map_hi, q.map_lo}), $past(TAG_PRIO));
  endproperty
  a_prio: assert property (p_prio) else $error("Priority map mismatch");

  property p_unknown;
    DA_VALID && DA_UNKNOWN && q.unk[`SGC_BIT_UNK_EN] |=> FWD_VALID && FWD_PORTS == $past(q.unk[2:0]);
  endproperty
  a_unknown: assert property (p_unknown) else $error("Unknown frame mask ignored");

  property p_p2_hit;
    MIIM_VALID && PHY_ADDR_OK && MIIM_PHY == PHY_ADDR + `SGC_PHY_STEP
      ##1 PHY_ADDR_OK |-> MIIM_HIT_P2;
  endproperty
  a_p2_hit: assert property (p_p2_hit) else $error("Port 2 PHY access missed");

  property p_phy_bad;
    PHY_ADDR inside {`SGC_PHY_BAD_LO, `SGC_PHY_BAD_HI0, `SGC_PHY_BAD_HI1}
      |=> !PHY_ADDR_OK && !MIIM_HIT_P1 && !MIIM_HIT_P2;
  endproperty
  a_phy_bad: assert property (p_phy_bad) else $error("Invalid PHY code accepted");

  property p_write;
    REG_WR && REG_ADDR == `SGC_ADDR_MAP_LO |=> q.map_lo == $past(REG_WDATA);
  endproperty
  a_write: assert property (p_write) else $error("Write not applied");

  property p_led;
    q.cap_cnt == `SGC_STRAP_CAP |=> LED_MODE[1] == $past(q.strap_s2[3]);
  endproperty
  a_led: assert property (p_led) else $error("LED strap not captured");

  c_drop:  cover property (FRM_END && LOOP_FILTER && FRM_CRC_ERR ##1 LOOP_DROP);
  c_unk:   cover property (DA_VALID && DA_UNKNOWN && q.unk[`SGC_BIT_UNK_EN]);
  c_p2hit: cover property (MIIM_HIT_P2);
endmodule
`default_nettype wire

// ==== tb/switch_global_config_regs_tb.sv ====
// Self-checking bench for the global configuration bank.
// Assumes sgc_regs and sgc_cfg.svh are on the compile and include paths.
`include "sgc_cfg.svh"
`default_nettype none
module switch_global_config_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst_n, wr, rd, fe, oam, crc, runt, giant, tag_v, da_v, da_unk, mv;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] strap;
  logic [2:0] tprio, da_p, fwd_p;
  logic [4:0] mphy, phy_a;
  logic [1:0] lpos, led, pq;
  logic       lflt, tmode, tpid, drop, pass, pv, fv, h1, h2, pok;
  int         n_mismatch, cmp_count;

  // Straps: {LED select high, filter, position low, LED select low}, set under reset
  sgc_regs sgc_regs_i (
    .CLK(clk), .RESET_N(rst_n), .STRAP_FILTER(strap[2]), .STRAP_POS(strap[1]),
    .STRAP_LED_LO(strap[0]), .STRAP_LED_HI(strap[3]), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .LOOP_FILTER(lflt),
    .TEST_MODE(tmode), .LOOP_POS(lpos), .LED_MODE(led), .DIRECT_TAG_EN(tpid),
    .FRM_END(fe), .FRM_OAM(oam), .FRM_CRC_ERR(crc), .FRM_RUNT(runt),
    .FRM_GIANT(giant), .LOOP_DROP(drop), .LOOP_PASS(pass), .TAG_VALID(tag_v),
    .TAG_PRIO(tprio), .PRIO_QUEUE(pq), .PRIO_VALID(pv), .DA_VALID(da_v),
    .DA_UNKNOWN(da_unk), .DA_PORTS(da_p), .FWD_PORTS(fwd_p), .FWD_VALID(fv),
    .MIIM_VALID(mv), .MIIM_PHY(mphy), .MIIM_HIT_P1(h1), .MIIM_HIT_P2(h2),
    .PHY_ADDR(phy_a), .PHY_ADDR_OK(pok));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic results();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Every driver moves 2 ns after a rising edge
  task automatic tick();
    @(posedge clk);
    #2;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    {addr, wdata, wr} = {a, d, 1'b1};
    tick();
    wr = 1'b0;
    tick();
  endtask

  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    {addr, rd} = {a, 1'b1};
    tick();
    chk(rdata, e);
    rd = 1'b0;
    tick();
    chk(rdata, 8'h00);
  endtask

  task automatic frm(input logic [3:0] f, input logic d);
    {oam, crc, runt, giant, fe} = {f, 1'b1};
    tick();
    chk({drop, pass}, {d, ~d});
    fe = 1'b0;
    tick();
  endtask

  task automatic tag(input logic [2:0] p, input logic [1:0] e);
    {tprio, tag_v} = {p, 1'b1};
    tick();
    chk({pv, pq}, {1'b1, e});
    tag_v = 1'b0;
    tick();
  endtask

  task automatic dst(input logic u, input logic [2:0] p, input logic [2:0] e);
    {da_unk, da_p, da_v} = {u, p, 1'b1};
    tick();
    chk({fv, fwd_p}, {1'b1, e});
    da_v = 1'b0;
    tick();
  endtask

  task automatic mii(input logic [4:0] a, input logic e1, input logic e2);
    {mphy, mv} = {a, 1'b1};
    tick();
    chk({h2, h1}, {e2, e1});
    mv = 1'b0;
    tick();
  endtask

  // Straps move only while reset is held; ctl writes wait until strap capture has finished
  task automatic s_reset(input logic [3:0] s);
    logic [1:0] p;
    logic [7:0] e;
    p = s[1] ? 2'h2 : 2'h1;
    e = {1'b0, s[2], 1'b0, p, s[3], s[0], 1'b0};
    {rst_n, strap} = {1'b0, s};
    repeat (8) tick();
    rst_n = 1'b1;
    repeat (6) tick();
    chk({1'b0, lflt, tmode, lpos, led, tpid}, e);
    chk({2'h0, pok, phy_a}, 8'h21);
    rreg(`SGC_ADDR_CTL, {s[3], 1'b0, s[2], 1'b0, 1'b1, s[1], s[0], 1'b0});
    rreg(`SGC_ADDR_MAP_LO, 8'h50);
    rreg(`SGC_ADDR_MAP_HI, 8'hFA);
    rreg(`SGC_ADDR_UNK, 8'h07);
    rreg(`SGC_ADDR_PHY, 8'h08);
    wreg(8'h10, 8'hFF);
    rreg(8'h10, 8'h00);
  endtask

  task automatic s_loop();
    for (int k = 0; k < 5; k++) frm(4'h8 >> k, k < 4);
    wreg(`SGC_ADDR_CTL, 8'h88);
    for (int k = 0; k < 5; k++) frm(4'h8 >> k, k == 0);
  endtask

  task automatic s_modes();
    logic [1:0] e;
    for (int i = 0; i < 4; i++) begin
      e = (i[0]) ? 2'd2 : {1'b0, i[1]};
      wreg(`SGC_ADDR_CTL, {i[1], 2'b01, 1'b0, i[1], i[0], i[0], i[0]});
      chk({lflt, tmode, lpos, led, tpid}, {2'b10, e, i[1], i[0], i[0]});
      chk({6'h0, led}, {6'h0, i[1], i[0]});
      chk({7'h0, tpid}, {7'h0, i[0]});
    end
  endtask

  task automatic s_prio();
    logic [15:0] m;
    m = 16'hFA50;
    for (int i = 0; i < 8; i++) tag(i[2:0], m[2*i+:2]);
    wreg(`SGC_ADDR_MAP_LO, 8'h1B);
    wreg(`SGC_ADDR_MAP_HI, 8'hE4);
    m = 16'hE41B;
    for (int i = 0; i < 8; i++) tag(i[2:0], m[2*i+:2]);
  endtask

  task automatic s_unk();
    dst(1'b1, 3'h2, 3'h2);
    wreg(`SGC_ADDR_UNK, 8'h85);
    dst(1'b1, 3'h2, 3'h5);
    dst(1'b0, 3'h2, 3'h2);
    wreg(`SGC_ADDR_UNK, 8'h80);
    dst(1'b1, 3'h3, 3'h0);
  endtask

  task automatic s_phy();
    mii(5'h01, 1'b1, 1'b0);
    mii(5'h02, 1'b0, 1'b1);
    mii(5'h03, 1'b0, 1'b0);
    wreg(`SGC_ADDR_PHY, 8'hF7);
    chk({7'h0, pok}, 8'h00);
    rreg(`SGC_ADDR_PHY, 8'hF0);
    mii(5'h1E, 1'b0, 1'b0);
    mii(5'h1F, 1'b0, 1'b0);
    wreg(`SGC_ADDR_PHY, 8'hE8);
    chk({2'h0, pok, phy_a}, 8'h3D);
    mii(5'h1D, 1'b1, 1'b0);
    mii(5'h1E, 1'b0, 1'b1);
    wreg(`SGC_ADDR_PHY, 8'h00);
    chk({2'h0, pok, phy_a}, 8'h00);
    mii(5'h00, 1'b0, 1'b0);
    mii(5'h01, 1'b0, 1'b0);
  endtask

  initial begin
    {wr, rd, fe, oam, crc, runt, giant, tag_v, da_v, da_unk, mv} = '0;
    {addr, wdata, tprio, da_p, mphy} = '0;
    {n_mismatch, cmp_count} = '0;
    s_reset(4'hD);
    s_loop();
    s_modes();
    s_prio();
    s_unk();
    s_phy();
    s_reset(4'h2);
    results();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #500us;
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
